/* hdl/gpio_port_consts.svh */
// Register map, field positions, reset values and timing constants of the timed masked GPIO port.
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

`define ADDR_IN_LEVEL        8'h00
`define ADDR_IN_SINGLE_SEL   8'h04
`define ADDR_IN_SINGLE_VAL   8'h08
`define ADDR_IN_RANGE_SEL    8'h0c
`define ADDR_IN_RANGE_VAL    8'h10
`define ADDR_IN_MASK         8'h14
`define ADDR_IN_MASKED_VAL   8'h18
`define ADDR_OUT_DELAY       8'h20
`define ADDR_OUT_SINGLE      8'h24
`define ADDR_OUT_RANGE       8'h28
`define ADDR_OUT_MASKED      8'h2c
`define ADDR_OUT_LEVEL       8'h30
`define ADDR_OUT_PENDING     8'h34
`define ADDR_PRESCALE        8'h38

`define FLD_FIRST_LSB        0
`define FLD_LAST_LSB         8
`define FLD_STATE_BIT        16
`define FLD_IDX_W            4

`define RST_SINGLE_SEL       4'h1
`define RST_RANGE_FIRST      4'h1
`define RST_RANGE_LAST       4'h5
`define RST_IN_MASK          16'h001f
`define RST_OUT_DELAY        32'h0000_0000
`define RST_OUT_LEVEL        16'h0000

`define SECOND_NS            1000000000
`define MCLK_PERIOD_NS       50

`endif

/* hdl/gpio_port_pkg.sv */
// Types shared by the timed masked GPIO port.
package gpio_port_pkg;

    typedef enum logic [1:0] {
        OUT_OP_NONE,
        OUT_OP_SINGLE,
        OUT_OP_RANGE,
        OUT_OP_MASKED
    } out_op_t;

    typedef logic [15:0] line_mask_t;

endpackage

/* hdl/timed_masked_gpio_port.sv */
// Timed masked GPIO port: five sampled inputs, twelve timed outputs, classic Wishbone register slave.
`timescale 1ns/1ns
`include "gpio_port_consts.svh"

module timed_masked_gpio_port
    import gpio_port_pkg::*;
#(
    parameter int          IN_LINES         = 5,
    parameter int          OUT_LINES        = 12,
    parameter int          DELAY_W          = 16,
    parameter logic [31:0] PRESCALE_DEFAULT = 32'(`SECOND_NS / `MCLK_PERIOD_NS)
) (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 wb_cyc,
    input  wire logic                 wb_stb,
    input  wire logic                 wb_we,
    input  wire logic [7:0]           wb_adr,
    input  wire logic [3:0]           wb_sel,
    input  wire logic [31:0]          wb_dat_w,
    output logic      [31:0]          wb_dat_r,
    output logic                      wb_ack,
    input  wire logic [IN_LINES-1:0]  din,
    output logic      [OUT_LINES-1:0] dout
);

    // Lines numbered from one; a first index above the last gives an empty mask.
    function automatic line_mask_t range_mask(input logic [`FLD_IDX_W-1:0] first,
                                              input logic [`FLD_IDX_W-1:0] last);
        line_mask_t m;
        m = '0;
        for (int i = 0; i < $bits(line_mask_t); i++) begin
            if ((5'(i + 1) >= {1'b0, first}) && (5'(i + 1) <= {1'b0, last})) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // One select bit enables eight data bits, so partial writes touch only their own lanes.
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  sel);
        return (old_val & ~lane_mask(sel)) | (new_val & lane_mask(sel));
    endfunction

    // Register map by byte offset; unmapped offsets answer with zero and ignore writes.
    //   0x00 input levels (read)          0x04 single line index
    //   0x08 single line level (read)     0x0c range first [3:0], last [11:8]
    //   0x10 range value (read)           0x14 input mask
    //   0x18 masked input value (read)    0x20 delay in seconds for later commands
    //   0x24 single line command          0x28 range command
    //   0x2c masked command               0x30 output levels (read)
    //   0x34 lines with a running delay   0x38 clock cycles per second
    // Commands carry the line index or mask in the low lanes and the state in bit 16.

    // Bus request decode.
    // The ack cycle never takes a request, so a strobe held one cycle too long cannot repeat a write.
    logic                 ack_q;
    logic [31:0]          dat_r_q;
    logic                 req;
    logic                 wr;
    logic [31:0]          wdata;

    assign req   = wb_cyc & wb_stb & ~ack_q;
    assign wr    = req & wb_we;
    assign wdata = wb_dat_w & lane_mask(wb_sel);

    // Software-written configuration.
    logic [`FLD_IDX_W-1:0] in_single_idx_q;
    logic [`FLD_IDX_W-1:0] in_range_first_q;
    logic [`FLD_IDX_W-1:0] in_range_last_q;
    logic [IN_LINES-1:0]   in_mask_q;
    logic [DELAY_W-1:0]    out_delay_q;
    logic [31:0]           prescale_q;

    // Input synchroniser: the first stage feeds only the second.
    logic [IN_LINES-1:0]   din_meta_q;
    logic [IN_LINES-1:0]   din_q;

    // Output state.
    logic [OUT_LINES-1:0]  dout_q;
    logic [OUT_LINES-1:0]  pending_q;
    logic [DELAY_W:0]      delay_cnt_q [OUT_LINES];

    // Seconds timebase.
    logic [31:0]           pre_cnt_q;
    logic                  tick_q;

    // Output command decode.
    out_op_t               out_op;
    logic [OUT_LINES-1:0]  out_sel;
    logic                  out_state;
    line_mask_t            wr_range;
    logic                  timed_cmd;
    logic [OUT_LINES-1:0]  expire;

    // Input read values.
    line_mask_t            single_mask;
    line_mask_t            in_range;
    logic [IN_LINES-1:0]   single_hit;
    logic [IN_LINES-1:0]   range_val;
    logic [IN_LINES-1:0]   masked_val;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            din_meta_q <= '0;
            din_q      <= '0;
        end else begin
            din_meta_q <= din;
            din_q      <= din_meta_q;
        end
    end

    // An index outside the input lines is kept as written and simply selects nothing.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            in_single_idx_q <= `RST_SINGLE_SEL;
        end else if (wr && wb_adr == `ADDR_IN_SINGLE_SEL && wb_sel[0]) begin
            in_single_idx_q <= wb_dat_w[`FLD_FIRST_LSB +: `FLD_IDX_W];
        end
    end

    // A range with its first line above its last selects nothing and reads zero.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            in_range_first_q <= `RST_RANGE_FIRST;
            in_range_last_q  <= `RST_RANGE_LAST;
        end else if (wr && wb_adr == `ADDR_IN_RANGE_SEL) begin
            if (wb_sel[0]) begin
                in_range_first_q <= wb_dat_w[`FLD_FIRST_LSB +: `FLD_IDX_W];
            end
            if (wb_sel[1]) begin
                in_range_last_q <= wb_dat_w[`FLD_LAST_LSB +: `FLD_IDX_W];
            end
        end
    end

    // Mask bits beyond the last input line are not stored, so they can never leak into a read.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            in_mask_q <= IN_LINES'(`RST_IN_MASK);
        end else if (wr && wb_adr == `ADDR_IN_MASK && wb_sel[0]) begin
            in_mask_q <= wb_dat_w[IN_LINES-1:0];
        end
    end

    // The delay is latched once and applies to every later output command until rewritten.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            out_delay_q <= DELAY_W'(`RST_OUT_DELAY);
        end else if (wr && wb_adr == `ADDR_OUT_DELAY) begin
            out_delay_q <= DELAY_W'(merge_lanes(32'(out_delay_q), wb_dat_w, wb_sel));
        end
    end

    // A smaller prescale is seen by the next comparison, so shrinking it never strands the counter.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prescale_q <= PRESCALE_DEFAULT;
        end else if (wr && wb_adr == `ADDR_PRESCALE) begin
            prescale_q <= merge_lanes(prescale_q, wb_dat_w, wb_sel);
        end
    end

    // Input reads: all selected lines come from one synchronised snapshot.
    assign single_mask = range_mask(in_single_idx_q, in_single_idx_q);
    assign in_range    = range_mask(in_range_first_q, in_range_last_q);
    assign single_hit  = din_q & single_mask[IN_LINES-1:0];
    assign range_val   = din_q & in_range[IN_LINES-1:0];
    assign masked_val  = din_q & in_mask_q;

    // Read data is zero outside the ack cycle so a stale word is never taken for an answer.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dat_r_q <= '0;
        end else if (req && !wb_we) begin
            unique case (wb_adr)
                `ADDR_IN_LEVEL:      dat_r_q <= 32'(din_q);
                `ADDR_IN_SINGLE_SEL: dat_r_q <= 32'(in_single_idx_q);
                `ADDR_IN_SINGLE_VAL: dat_r_q <= {31'h0000_0000, |single_hit};
                `ADDR_IN_RANGE_SEL: begin
                    dat_r_q <= (32'(in_range_last_q) << `FLD_LAST_LSB) | 32'(in_range_first_q);
                end
                `ADDR_IN_RANGE_VAL:  dat_r_q <= 32'(range_val);
                `ADDR_IN_MASK:       dat_r_q <= 32'(in_mask_q);
                `ADDR_IN_MASKED_VAL: dat_r_q <= 32'(masked_val);
                `ADDR_OUT_DELAY:     dat_r_q <= 32'(out_delay_q);
                `ADDR_OUT_LEVEL:     dat_r_q <= 32'(dout_q);
                `ADDR_OUT_PENDING:   dat_r_q <= 32'(pending_q);
                `ADDR_PRESCALE:      dat_r_q <= prescale_q;
                default:             dat_r_q <= '0;
            endcase
        end else begin
            dat_r_q <= '0;
        end
    end

    // Output commands act on any write that enables the state lane; low lanes left unselected read as zero.
    always_comb begin
        out_op   = OUT_OP_NONE;
        wr_range = '0;
        out_sel  = '0;
        if (wr && wb_sel[2]) begin
            unique case (wb_adr)
                `ADDR_OUT_SINGLE: out_op = OUT_OP_SINGLE;
                `ADDR_OUT_RANGE:  out_op = OUT_OP_RANGE;
                `ADDR_OUT_MASKED: out_op = OUT_OP_MASKED;
                default:          out_op = OUT_OP_NONE;
            endcase
        end
        unique case (out_op)
            OUT_OP_SINGLE: begin
                wr_range = range_mask(wdata[`FLD_FIRST_LSB +: `FLD_IDX_W],
                                      wdata[`FLD_FIRST_LSB +: `FLD_IDX_W]);
                out_sel  = wr_range[OUT_LINES-1:0];
            end
            OUT_OP_RANGE: begin
                wr_range = range_mask(wdata[`FLD_FIRST_LSB +: `FLD_IDX_W],
                                      wdata[`FLD_LAST_LSB +: `FLD_IDX_W]);
                out_sel  = wr_range[OUT_LINES-1:0];
            end
            OUT_OP_MASKED: begin
                out_sel = wdata[OUT_LINES-1:0];
            end
            OUT_OP_NONE: begin
                out_sel = '0;
            end
        endcase
    end

    assign out_state = wdata[`FLD_STATE_BIT];

    // A zero prescale counts as one cycle per tick so the timebase never stalls.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pre_cnt_q <= '0;
            tick_q    <= 1'b0;
        end else if (pre_cnt_q + 32'h0000_0001 >= prescale_q) begin
            pre_cnt_q <= '0;
            tick_q    <= 1'b1;
        end else begin
            pre_cnt_q <= pre_cnt_q + 32'h0000_0001;
            tick_q    <= 1'b0;
        end
    end

    // The counter is loaded with delay plus one because the tick phase at the write is unknown;
    // this keeps the level at least the full delay, at the cost of up to one extra second.
    assign timed_cmd = (out_delay_q != '0);

    // A line expires on the tick that finds its counter at one.
    always_comb begin
        for (int i = 0; i < OUT_LINES; i++) begin
            expire[i] = tick_q && pending_q[i] && (delay_cnt_q[i] == (DELAY_W + 1)'(1));
        end
    end

    // A command wins over a reversal in the same cycle, which is what cancels a running delay.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dout_q <= OUT_LINES'(`RST_OUT_LEVEL);
        end else begin
            for (int i = 0; i < OUT_LINES; i++) begin
                if (out_sel[i]) begin
                    dout_q[i] <= out_state;
                end else if (expire[i]) begin
                    dout_q[i] <= ~dout_q[i];
                end
            end
        end
    end

    // Unselected lines keep their flags and timers, apart from their own countdown and expiry.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pending_q <= '0;
        end else begin
            for (int i = 0; i < OUT_LINES; i++) begin
                if (out_sel[i]) begin
                    pending_q[i] <= timed_cmd;
                end else if (expire[i]) begin
                    pending_q[i] <= 1'b0;
                end
            end
        end
    end

    // Each line counts its own delay in ticks.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < OUT_LINES; i++) begin
                delay_cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < OUT_LINES; i++) begin
                if (out_sel[i] && timed_cmd) begin
                    delay_cnt_q[i] <= {1'b0, out_delay_q} + (DELAY_W + 1)'(1);
                end else if (out_sel[i] || expire[i]) begin
                    delay_cnt_q[i] <= '0;
                end else if (tick_q && pending_q[i]) begin
                    delay_cnt_q[i] <= delay_cnt_q[i] - (DELAY_W + 1)'(1);
                end
            end
        end
    end

    assign wb_ack   = ack_q;
    assign wb_dat_r = dat_r_q;
    assign dout     = dout_q;

endmodule // timed_masked_gpio_port

/* test/gpio_port_chk.sv */
// Concurrent checks on the pins of the timed masked GPIO port.
`timescale 1ns/1ns
`include "gpio_port_consts.svh"

module gpio_port_chk #(
    parameter int IN_LINES  = 5,
    parameter int OUT_LINES = 12
) (
    input wire logic                 mclk,
    input wire logic                 resetn,
    input wire logic                 wb_cyc,
    input wire logic                 wb_stb,
    input wire logic                 wb_we,
    input wire logic [7:0]           wb_adr,
    input wire logic [3:0]           wb_sel,
    input wire logic [31:0]          wb_dat_w,
    input wire logic [31:0]          wb_dat_r,
    input wire logic                 wb_ack,
    input wire logic [IN_LINES-1:0]  din,
    input wire logic [OUT_LINES-1:0] dout
);
    logic        take;
    logic        cmd_wr;
    logic [15:0] dly_q;
    logic        timed_q;

    assign take   = wb_cyc && wb_stb && !wb_ack;
    assign cmd_wr = take && wb_we && wb_sel[2] && (wb_adr inside {`ADDR_OUT_SINGLE, `ADDR_OUT_RANGE, `ADDR_OUT_MASKED});

    // Once any timed command is issued a reversal may land at any edge, so the hold check stands down.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dly_q <= 16'h0000;
        end else if (take && wb_we && wb_adr == `ADDR_OUT_DELAY) begin
            dly_q <= wb_dat_w[15:0];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            timed_q <= 1'b0;
        end else if (cmd_wr && dly_q != 16'h0000) begin
            timed_q <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    AST_ACK_ONE: assert property (take |=> wb_ack)
        else $error("request not acknowledged in the next cycle");
    AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack)
        else $error("acknowledge longer than one cycle");
    AST_DAT_IDLE: assert property (!wb_ack |-> wb_dat_r == 32'h0)
        else $error("read data not zero outside acknowledge");
    AST_IN_WIDTH: assert property (take && !wb_we && (wb_adr inside {`ADDR_IN_LEVEL, `ADDR_IN_RANGE_VAL,
        `ADDR_IN_MASKED_VAL}) |=> wb_dat_r[31:IN_LINES] == '0)
        else $error("input read shows lines beyond the fifth");
    AST_SINGLE_BIT: assert property (take && !wb_we && wb_adr == `ADDR_IN_SINGLE_VAL |=> wb_dat_r[31:1] == '0)
        else $error("single line read wider than one bit");
    AST_OUT_READ: assert property (take && !wb_we && wb_adr == `ADDR_OUT_LEVEL |=> wb_dat_r == 32'($past(dout)))
        else $error("output level read differs from the pins");
    AST_SINGLE_WR: assert property (cmd_wr && wb_sel[0] && wb_adr == `ADDR_OUT_SINGLE && (wb_dat_w[3:0] inside {[1:12]})
        |=> dout[$past(wb_dat_w[3:0]) - 4'h1] == $past(wb_dat_w[16]))
        else $error("single line write did not apply its state");
    AST_MASKED_WR: assert property (cmd_wr && wb_sel[1:0] == 2'h3 && wb_adr == `ADDR_OUT_MASKED
        |=> ((dout ^ {OUT_LINES{$past(wb_dat_w[16])}}) & $past(wb_dat_w[OUT_LINES-1:0])) == '0)
        else $error("masked write did not apply its state to every selected line");
    AST_HOLD: assert property (!timed_q && !$past(cmd_wr) |-> $stable(dout))
        else $error("output lines changed with no command");

    COV_READ: cover property (take && !wb_we);
    COV_MASKED: cover property (cmd_wr && wb_adr == `ADDR_OUT_MASKED);
    COV_REVERT: cover property (timed_q && $fell(dout[0]));
endmodule // gpio_port_chk

bind timed_masked_gpio_port gpio_port_chk #(.IN_LINES(IN_LINES), .OUT_LINES(OUT_LINES)) chk (.mclk, .resetn,
    .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .din, .dout);

/* test/switch_gear.sv */
// Model of the external switching equipment wired to the port's connector.
`timescale 1ns/1ns

module switch_gear (
    input  wire logic        mclk,
    input  wire logic [4:0]  level,
    output logic      [4:0]  din
);
    // Contacts change just after an edge so the port's synchroniser never sees a half-made level.
    initial din = 5'h00;
    always @(posedge mclk) din <= level;
endmodule // switch_gear

/* test/tb_timed_masked_gpio_port.sv */
// Self-checking bench for the timed masked GPIO port.
`timescale 1ns/1ns
`include "gpio_port_consts.svh"

module tb_timed_masked_gpio_port;
    logic        mclk     = 1'b0;
    logic        resetn   = 1'b0;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [7:0]  wb_adr   = 8'h00;
    logic [3:0]  wb_sel   = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic [4:0]  level    = 5'h15;
    logic [4:0]  din;
    logic [11:0] dout;
    logic [31:0] rdat;
    int          errors   = 0;
    int          checked  = 0;
    int          n;

    always #25 mclk = ~mclk;

    // A four-cycle second keeps every timed case short.
    timed_masked_gpio_port #(.PRESCALE_DEFAULT(32'h4)) DUT (.mclk, .resetn, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
        .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .din, .dout);
    switch_gear far (.mclk, .level, .din);

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int k;
        k = 0;
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= 4'hf;
        wb_dat_w <= dat;
        do begin
            @(posedge mclk);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        chk("ack", 32'h1, {31'h0, wb_ack});
        rdat = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string name);
        bus(1'b0, adr, 32'h0);
        chk(name, exp, rdat);
    endtask

    task automatic outc(input logic [11:0] e);
        chk("dout", {20'h0, e}, {20'h0, dout});
        rd(`ADDR_OUT_LEVEL, {20'h0, e}, "out_level");
    endtask

    initial begin
        #(50 * 3000);
        errors++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(`ADDR_PRESCALE, 32'h4, "prescale");
        rd(`ADDR_IN_LEVEL, 32'h15, "in_level");
        for (int i = 1; i <= 5; i++) begin
            bus(1'b1, `ADDR_IN_SINGLE_SEL, 32'(i));
            rd(`ADDR_IN_SINGLE_VAL, {31'h0, level[i-1]}, "in_single");
        end
        bus(1'b1, `ADDR_IN_RANGE_SEL, 32'h0503);
        rd(`ADDR_IN_RANGE_VAL, 32'd20, "in_range");
        bus(1'b1, `ADDR_IN_MASK, 32'd19);
        rd(`ADDR_IN_MASKED_VAL, 32'd17, "in_masked");
        bus(1'b1, `ADDR_IN_MASK, 32'h0);
        rd(`ADDR_IN_MASKED_VAL, 32'h0, "in_masked_none");
        rd(8'h3c, 32'h0, "unmapped");
        $display("inputs done");
        bus(1'b1, `ADDR_OUT_SINGLE, 32'h1_0003);
        outc(12'h004);
        bus(1'b1, `ADDR_OUT_RANGE, 32'h1_0503);
        outc(12'h01c);
        bus(1'b1, `ADDR_OUT_SINGLE, 32'h0_0003);
        outc(12'h018);
        bus(1'b1, `ADDR_OUT_MASKED, 32'h1_08d6);
        outc(12'h8de);
        bus(1'b1, `ADDR_OUT_MASKED, 32'h0_08d6);
        outc(12'h008);
        $display("outputs done");
        bus(1'b1, `ADDR_OUT_DELAY, 32'h2);
        bus(1'b1, `ADDR_OUT_MASKED, 32'h1_0003);
        outc(12'h00b);
        repeat (2) @(posedge mclk);
        chk("dout_held", 32'h00b, {20'h0, dout});
        rd(`ADDR_OUT_PENDING, 32'h003, "pending_set");
        n = 0;
        while (dout !== 12'h008 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        chk("dout_reverted", 32'h008, {20'h0, dout});
        rd(`ADDR_OUT_PENDING, 32'h0, "pending_done");
        bus(1'b1, `ADDR_OUT_SINGLE, 32'h1_0001);
        outc(12'h009);
        bus(1'b1, `ADDR_OUT_DELAY, 32'h0);
        bus(1'b1, `ADDR_OUT_SINGLE, 32'h0_0001);
        outc(12'h008);
        repeat (20) @(posedge mclk);
        chk("dout_cancelled", 32'h008, {20'h0, dout});
        rd(`ADDR_OUT_PENDING, 32'h0, "pending_cancelled");
        $display("timed done");
        close_out();
    end
endmodule // tb_timed_masked_gpio_port
